//--- src/asrc_regs.vh
// timing constants and geometry for the async sram host controller
// assumes a 200 MHz controller clock and one 32k x 8 static ram outside
`ifndef ASRC_REGS_VH
`define ASRC_REGS_VH
`define ASRC_ADDR_W 15
`define ASRC_DATA_W 8
`define ASRC_CLK_PS 5000
// times in ns as printed
`define ASRC_T_ADDR_ACCESS_NS 40
`define ASRC_T_SEL_ACCESS_NS 40
`define ASRC_T_OE_ACCESS_NS 15
`define ASRC_T_MIN_CYCLE_NS 40
`define ASRC_T_WR_PULSE_NS 35
`define ASRC_T_SEL_TO_END_NS 35
`define ASRC_T_WR_FLOAT_NS 15
`define ASRC_T_OE_FLOAT_NS 15
`define ASRC_T_DATA_SETUP_NS 35
`define ASRC_T_WR_DISABLE_NS 5
// least times rounded up to cycles
`define ASRC_CYC(ns) (((ns) * 1000 + `ASRC_CLK_PS - 1) / `ASRC_CLK_PS)
`define ASRC_RD_CYC `ASRC_CYC(`ASRC_T_ADDR_ACCESS_NS)
`define ASRC_WR_CYC `ASRC_CYC(`ASRC_T_WR_PULSE_NS)
`define ASRC_FLT_CYC `ASRC_CYC(`ASRC_T_OE_FLOAT_NS)
`define ASRC_REC_CYC `ASRC_CYC(`ASRC_T_WR_DISABLE_NS)
`endif

//--- src/asrc_cnt.v
// down counter timing the phases of one ram access
// assumes load and enable come from logic on the same clock
`timescale 1ns/1ps
module asrc_cnt (
   input  wire       clk,
   input  wire       nrst,
   input  wire       ce,
   input  wire       load,
   input  wire [3:0] load_val,
   output reg        done_q
);
   reg [3:0] cnt_q;
   // load then count to zero
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q  <= 4'h0;
         done_q <= 1'b1;
      end else if (ce) begin
         if (load) begin
            cnt_q  <= load_val;
            done_q <= (load_val == 4'h0);
         end else if (cnt_q != 4'h0) begin
            cnt_q  <= cnt_q - 4'h1;
            done_q <= (cnt_q == 4'h1);
         end
      end
   end
endmodule

//--- src/asrc_host.v
// host controller driving a 32k x 8 asynchronous static ram
// assumes one 200 MHz clock; ram data pins come back asynchronously
`timescale 1ns/1ps
`include "asrc_regs.vh"
module asrc_host (
   input  wire        CLK,
   input  wire        NRST,
   input  wire        CE,
   input  wire        REQ_VALID,
   input  wire        REQ_WRITE,
   input  wire [14:0] REQ_ADDR,
   input  wire [7:0]  REQ_WDATA,
   output reg         REQ_READY,
   output reg         RSP_VALID,
   output reg  [7:0]  RSP_RDATA,
   output reg  [14:0] MEM_ADDR,
   output reg         MEM_CHIP_SELECT_N,
   output reg         MEM_WRITE_STROBE_N,
   output reg         MEM_OUTPUT_ENABLE_N,
   input  wire [7:0]  MEM_DATA_I,
   output reg  [7:0]  MEM_DATA_O,
   output reg         MEM_DATA_OE
);
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_RD    = 3'h1;
   localparam [2:0] ST_RSYNC = 3'h2;
   localparam [2:0] ST_WFLT  = 3'h3;
   localparam [2:0] ST_WR    = 3'h4;
   localparam [2:0] ST_REC   = 3'h5;
   // cycle counts worked out wide, then cut to the timer width
   localparam integer RD_CYC_N  = `ASRC_RD_CYC;
   localparam integer WR_CYC_N  = `ASRC_WR_CYC;
   localparam integer FLT_CYC_N = `ASRC_FLT_CYC;
   localparam integer REC_CYC_N = `ASRC_REC_CYC;
   localparam [3:0] RD_CYC   = RD_CYC_N[3:0];
   localparam [3:0] WR_CYC   = WR_CYC_N[3:0];
   localparam [3:0] FLT_CYC  = FLT_CYC_N[3:0];
   localparam [3:0] REC_CYC  = REC_CYC_N[3:0];

   reg  [2:0] state_q;
   reg  [2:0] state_d;
   reg        load;
   reg  [3:0] load_val;
   wire       done;
   reg  [7:0] sync1_q;
   reg  [7:0] sync2_q;
   reg        sync_wait_q;
   wire       take;

   // a request counts only while ready is shown
   assign take = (state_q == ST_IDLE) && REQ_VALID && REQ_READY;

   asrc_cnt u_cnt (
      .clk      (CLK),
      .nrst     (NRST),
      .ce       (CE),
      .load     (load),
      .load_val (load_val),
      .done_q   (done)
   );

   // two-stage capture of ram data pins
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end else if (CE) begin
         sync1_q <= MEM_DATA_I;
         sync2_q <= sync1_q;
      end
   end

   // next state and phase timer loads
   always @* begin
      state_d  = state_q;
      load     = 1'b0;
      load_val = 4'h0;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               load = 1'b1;
               if (REQ_WRITE) begin
                  state_d  = ST_WFLT;
                  load_val = FLT_CYC;
               end else begin
                  state_d  = ST_RD;
                  load_val = RD_CYC;
               end
            end
         end
         ST_RD: begin
            if (done) begin
               state_d = ST_RSYNC;
            end
         end
         ST_RSYNC: begin
            if (sync_wait_q) begin
               state_d  = ST_REC;
               load     = 1'b1;
               load_val = FLT_CYC;
            end
         end
         ST_WFLT: begin
            if (done) begin
               state_d  = ST_WR;
               load     = 1'b1;
               load_val = WR_CYC;
            end
         end
         ST_WR: begin
            if (done) begin
               state_d  = ST_REC;
               load     = 1'b1;
               load_val = REC_CYC;
            end
         end
         ST_REC: begin
            if (done) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // pins and handshake, all from flip-flops
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_q             <= ST_IDLE;
         sync_wait_q         <= 1'b0;
         REQ_READY           <= 1'b0;
         RSP_VALID           <= 1'b0;
         RSP_RDATA           <= 8'h00;
         MEM_ADDR            <= 15'h0000;
         MEM_CHIP_SELECT_N   <= 1'b1;
         MEM_WRITE_STROBE_N  <= 1'b1;
         MEM_OUTPUT_ENABLE_N <= 1'b1;
         MEM_DATA_O          <= 8'h00;
         MEM_DATA_OE         <= 1'b0;
      end else if (CE) begin
         state_q   <= state_d;
         RSP_VALID <= 1'b0;
         REQ_READY <= (state_d == ST_IDLE) && !take;
         case (state_q)
            ST_IDLE: begin
               if (take) begin
                  MEM_ADDR          <= REQ_ADDR;
                  MEM_CHIP_SELECT_N <= 1'b0;
                  REQ_READY         <= 1'b0;
                  if (REQ_WRITE) begin
                     MEM_DATA_O          <= REQ_WDATA;
                     MEM_WRITE_STROBE_N  <= 1'b0;
                     MEM_OUTPUT_ENABLE_N <= 1'b1;
                  end else begin
                     MEM_WRITE_STROBE_N  <= 1'b1;
                     MEM_OUTPUT_ENABLE_N <= 1'b0;
                  end
               end
            end
            ST_RD: begin
               // address, enable and strobe held; wait for the access timer
               sync_wait_q <= 1'b0;
               if (done) begin
                  sync_wait_q <= 1'b0;
               end
            end
            ST_RSYNC: begin
               // data sampled two edges after access delay
               sync_wait_q <= 1'b1;
               if (sync_wait_q) begin
                  RSP_RDATA           <= sync2_q;
                  RSP_VALID           <= 1'b1;
                  MEM_OUTPUT_ENABLE_N <= 1'b1;
                  MEM_CHIP_SELECT_N   <= 1'b1;
                  sync_wait_q         <= 1'b0;
               end
            end
            ST_WFLT: begin
               if (done) begin
                  MEM_DATA_OE <= 1'b1;
               end
            end
            ST_WR: begin
               if (done) begin
                  MEM_WRITE_STROBE_N <= 1'b1;
                  MEM_CHIP_SELECT_N  <= 1'b1;
                  RSP_VALID          <= 1'b1;
               end
            end
            ST_REC: begin
               MEM_DATA_OE <= 1'b0;
            end
            default: begin
               MEM_CHIP_SELECT_N <= 1'b1;
            end
         endcase
      end
   end
endmodule

//--- sim/asrc_host_asserts.sv
// pin timing checker for the ram host
// bound to asrc_host, sees its ports only
`timescale 1ns/1ps
module asrc_chk (
   input wire        CLK,
   input wire        NRST,
   input wire [14:0] MEM_ADDR,
   input wire        MEM_CHIP_SELECT_N,
   input wire        MEM_WRITE_STROBE_N,
   input wire        MEM_OUTPUT_ENABLE_N,
   input wire        MEM_DATA_OE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   // write start, write end and read hold phases
   sequence wr_go;
      $fell(MEM_WRITE_STROBE_N);
   endsequence
   sequence wr_end;
      $rose(MEM_CHIP_SELECT_N) && !$past(MEM_WRITE_STROBE_N);
   endsequence
   sequence rd_hold;
      ($stable(MEM_ADDR) && !MEM_OUTPUT_ENABLE_N && MEM_WRITE_STROBE_N) [*7];
   endsequence
   AST_CYCLE: assert property ($changed(MEM_ADDR) |=> $stable(MEM_ADDR) [*7])
      else $error("address changed too soon");
   AST_RD_HOLD: assert property ($fell(MEM_CHIP_SELECT_N) && MEM_WRITE_STROBE_N |=> rd_hold)
      else $error("read pins moved");
   AST_WR_PULSE: assert property (wr_go |-> !MEM_WRITE_STROBE_N [*7])
      else $error("write pulse short");
   AST_WR_SEL: assert property (wr_go |-> !MEM_CHIP_SELECT_N [*7])
      else $error("select short before write end");
   AST_FLOAT: assert property (wr_go |-> !MEM_DATA_OE [*3])
      else $error("data driven too early");
   AST_NO_FIGHT: assert property (MEM_DATA_OE |-> MEM_OUTPUT_ENABLE_N)
      else $error("data driven with ram outputs on");
   AST_WR_END: assert property (wr_end |-> $past(MEM_DATA_OE))
      else $error("write ended without data");
endmodule
bind asrc_host asrc_chk asrc_chk_i (.CLK(CLK), .NRST(NRST), .MEM_ADDR(MEM_ADDR),
   .MEM_CHIP_SELECT_N(MEM_CHIP_SELECT_N), .MEM_WRITE_STROBE_N(MEM_WRITE_STROBE_N),
   .MEM_OUTPUT_ENABLE_N(MEM_OUTPUT_ENABLE_N), .MEM_DATA_OE(MEM_DATA_OE));

//--- sim/asrc_ram.sv
// behavioural 32k x 8 static ram
// resolves host drive and ram drive on the data wire
`timescale 1ns/1ps
module asrc_ram (
   input  wire [14:0] addr,
   input  wire        cs_n,
   input  wire        we_n,
   input  wire        oe_n,
   input  wire        d_oe,
   input  wire [7:0]  d_o,
   output wire [7:0]  dq
);
   reg     [7:0] mem [0:32767];
   reg     [7:0] junk = 8'hA5;
   integer       gen = 0;
   integer       tok = 0;
   wire          rd = !cs_n && we_n && !oe_n;
   wire          wr = !cs_n && !we_n;
   // floating wire shows a changing pattern
   always #1 junk = ~junk;
   // access timer restarts on the latest change
   always @(addr or cs_n or we_n or oe_n) begin
      gen = gen + 1;
      tok <= #40 gen;
   end
   assign dq = d_oe ? d_o : (rd && tok == gen) ? mem[addr] : junk;
   // store when the write ends
   always @(negedge wr) mem[addr] <= dq;
endmodule

//--- sim/asrc_host_tb.sv
// bench for the ram host with a ram model
// assumes the model and checker are compiled first
`timescale 1ns/1ps
module asrc_host_tb;
   reg          clk = 1'b0;
   reg          nrst = 1'b0;
   reg          ce = 1'b1;
   reg          rq = 1'b0;
   reg          rq_w = 1'b0;
   reg   [14:0] rq_a = 15'h0000;
   reg   [7:0]  rq_d = 8'h00;
   wire         rdy, rsp, cs_n, we_n, oe_n, d_oe;
   wire  [7:0]  rdat, d_o, dq;
   wire  [14:0] ma;
   integer      n_mismatch = 0;
   integer      n_checks = 0;
   integer      i;
   always #2.5 clk = ~clk;
   asrc_host asrc_host_i (.CLK(clk), .NRST(nrst), .CE(ce), .REQ_VALID(rq),
      .REQ_WRITE(rq_w), .REQ_ADDR(rq_a), .REQ_WDATA(rq_d), .REQ_READY(rdy),
      .RSP_VALID(rsp), .RSP_RDATA(rdat), .MEM_ADDR(ma), .MEM_CHIP_SELECT_N(cs_n),
      .MEM_WRITE_STROBE_N(we_n), .MEM_OUTPUT_ENABLE_N(oe_n), .MEM_DATA_I(dq),
      .MEM_DATA_O(d_o), .MEM_DATA_OE(d_oe));
   asrc_ram asrc_ram_i (.addr(ma), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
      .d_oe(d_oe), .d_o(d_o), .dq(dq));
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_mismatch);
         if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task check(input [15:0] got, input [15:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // one request, held until taken, then wait for the answer
   task access(input w, input [14:0] a, input [7:0] d);
      integer k;
      begin
         @(negedge clk);
         while (rdy !== 1'b1) @(negedge clk);
         rq = 1'b1;
         rq_w = w;
         rq_a = a;
         rq_d = d;
         @(negedge clk);
         rq = 1'b0;
         k = 0;
         while (rsp !== 1'b1 && k < 40) begin
            @(negedge clk);
            k = k + 1;
         end
         if (rsp !== 1'b1) n_mismatch = n_mismatch + 1;
      end
   endtask
   // idle pins after reset
   task sc_idle;
      begin
         check(cs_n, 1'b1);
         check(d_oe, 1'b0);
      end
   endtask
   // boundary addresses written then read back
   task sc_fill;
      begin
         for (i = 0; i < 4; i = i + 1) access(1'b1, 15'h7FFF >> (5 * i), 8'hC3 ^ i[7:0]);
         for (i = 0; i < 4; i = i + 1) begin
            access(1'b0, 15'h7FFF >> (5 * i), 8'h00);
            check(rdat, 8'hC3 ^ i[7:0]);
         end
      end
   endtask
   // overwrite word 0000, top word 7FFF kept
   task sc_over;
      begin
         access(1'b1, 15'h0000, 8'h3C);
         access(1'b0, 15'h0000, 8'h00);
         check(rdat, 8'h3C);
         access(1'b0, 15'h7FFF, 8'h00);
         check(rdat, 8'hC3);
      end
   endtask
   // clock enable low freezes a read half way
   task sc_freeze;
      integer k;
      begin
         while (rdy !== 1'b1) @(negedge clk);
         rq = 1'b1;
         rq_w = 1'b0;
         rq_a = 15'h0000;
         @(negedge clk);
         rq = 1'b0;
         repeat (3) @(negedge clk);
         ce = 1'b0;
         repeat (20) @(negedge clk);
         check(cs_n, 1'b0);
         check(oe_n, 1'b0);
         check(rsp, 1'b0);
         ce = 1'b1;
         k = 0;
         while (rsp !== 1'b1 && k < 40) begin
            @(negedge clk);
            k = k + 1;
         end
         check(rsp, 1'b1);
         check(rdat, 8'h3C);
      end
   endtask
   // reset in mid-run: pins idle, ready late, stored words kept
   task sc_rst;
      begin
         @(negedge clk);
         nrst = 1'b0;
         repeat (2) @(negedge clk);
         check(cs_n, 1'b1);
         check(rdy, 1'b0);
         check(d_oe, 1'b0);
         nrst = 1'b1;
         @(negedge clk);
         check(rdy, 1'b1);
         access(1'b0, 15'h0000, 8'h00);
         check(rdat, 8'h3C);
      end
   endtask
   initial begin
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      sc_idle;
      sc_fill;
      sc_over;
      sc_freeze;
      sc_rst;
      report_and_stop;
   end
   // cut a hang short
   initial begin
      #20000;
      n_mismatch = n_mismatch + 1;
      report_and_stop;
   end
endmodule
